// file: rtl/cpu_pkg.sv
package cpu_pkg;
	// ----------------------------------------
	// Register map (byte offsets on the plain port)
	// ----------------------------------------
	localparam logic [7:0] ADDR_UNIT_CONTROL = 8'h17;
	localparam logic [7:0] ADDR_DUTY_LOW = 8'h15;
	localparam logic [7:0] ADDR_DUTY_SHADOW = 8'h16;
	localparam logic [7:0] ADDR_PERIOD_REG = 8'h92;
	localparam logic [7:0] ADDR_PERIOD_TIMER = 8'h11;
	localparam logic [7:0] ADDR_TIMER_CTRL = 8'h12;
	localparam logic [7:0] ADDR_PIN_DIR = 8'h87;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTL_DLSB_HI = 5;
	localparam int CTL_DLSB_LO = 4;
	localparam int TCTL_ON_BIT = 2;
	localparam int PIN_DIR_BIT = 2;
	localparam logic [3:0] MODE_PWM_A = 4'hc;
	localparam logic [1:0] MODE_PWM_HI = 2'h3;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_PERIOD = 8'hff;
	localparam logic [7:0] RST_DIR = 8'hff;
	localparam logic [1:0] PRE_DIV1 = 2'h0;
	localparam logic [1:0] PRE_DIV4 = 2'h1;
	localparam logic [3:0] POST_ONE = 4'h0;
	localparam logic [1:0] ONE2 = 2'h1;
	localparam logic [3:0] ONE4 = 4'h1;
	localparam logic [7:0] ONE8 = 8'h01;
	localparam int CTL_MODE_HI = 3;
	localparam int CTL_MODE_LO = 0;
	localparam int CTL_PWM_LO = 2;
	localparam int PRE_SEL_HI = 1;
	localparam int PRE_SEL_LO = 0;
	localparam int POST_HI = 6;
	localparam int POST_LO = 3;
	localparam int STATUS_FLAG_BIT = 0;
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [1:0] PRE_ZERO = 2'h0;
	localparam logic [1:0] PRE_WRAP = 2'h3;
	localparam logic [9:0] ON_TIME_ZERO = 10'h000;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		CPU_OFF,
		CPU_CAPTURE,
		CPU_COMPARE,
		CPU_PWM
	} cpu_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} cpu_bus_t;
endpackage : cpu_pkg

// file: rtl/cpu_pwm_unit.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
module cpu_pwm_unit (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	output logic PIN_OUT,
	output logic PIN_OE,
	output logic PERIOD_FLAG
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	cpu_pkg::cpu_bus_t bus;
	logic [7:0] ctl_reg;
	logic [7:0] duty_low_reg;
	logic [7:0] duty_shadow_reg;
	logic [1:0] hidden_lsb_reg;
	logic [7:0] period_reg;
	logic [7:0] timer_reg;
	logic [7:0] timer_next;
	logic [7:0] tctl_reg;
	logic [7:0] dir_reg;
	logic [1:0] pre_reg;
	logic [3:0] post_reg;
	logic latch_reg;
	logic flag_reg;
	logic [7:0] rdata_next;
	cpu_pkg::cpu_mode_t mode;
	logic pwm_on;
	logic timer_run;
	logic tick;
	logic match;
	logic [9:0] ext_count;
	logic [9:0] on_time;
	logic [1:0] pre_next;
	logic period_end;
	logic post_done;
	logic status_wr;
	logic [9:0] next_on_time;

	assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------

	// Address compare shared by all registers
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] b);
		hit = (a == b);
	endfunction : hit

	// Write strobe aimed at one register
	function automatic logic wr_to(input cpu_pkg::cpu_bus_t b,
		input logic [7:0] a);
		wr_to = b.wr && hit(b.addr, a);
	endfunction : wr_to

	// Ten-bit on-time from a duty byte and two low bits
	function automatic logic [9:0] join_on_time(input logic [7:0] duty,
		input logic [1:0] lsb);
		join_on_time = {duty, lsb};
	endfunction : join_on_time

	// Timer extended by the quarter-cycle count
	function automatic logic [9:0] ext_of(input logic [7:0] timer,
		input logic [1:0] quarter);
		ext_of = {timer, quarter};
	endfunction : ext_of

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	// Mode field: 0000 off, 11xx selects PWM, other 0xxx capture, 10xx compare
	always_comb begin
		if (ctl_reg[cpu_pkg::CTL_MODE_HI:cpu_pkg::CTL_MODE_LO] ==
			cpu_pkg::MODE_OFF)
			mode = cpu_pkg::CPU_OFF;
		else if (ctl_reg[cpu_pkg::CTL_MODE_HI:cpu_pkg::CTL_PWM_LO] ==
			cpu_pkg::MODE_PWM_HI)
			mode = cpu_pkg::CPU_PWM;
		else if (!ctl_reg[cpu_pkg::CTL_MODE_HI])
			mode = cpu_pkg::CPU_CAPTURE;
		else
			mode = cpu_pkg::CPU_COMPARE;
	end

	assign pwm_on = (mode == cpu_pkg::CPU_PWM);
	assign timer_run = tctl_reg[cpu_pkg::TCTL_ON_BIT];

	// ----------------------------------------
	// Prescaler and period timer
	// ----------------------------------------
	// Prescaler bits extend the timer to ten bits
	always_comb begin
		tick = 1'b0;
		if (timer_run) begin
			case (tctl_reg[cpu_pkg::PRE_SEL_HI:cpu_pkg::PRE_SEL_LO])
			cpu_pkg::PRE_DIV1: tick = 1'b1;
			cpu_pkg::PRE_DIV4: tick = (pre_reg == cpu_pkg::PRE_WRAP);
			default: tick = (pre_reg == cpu_pkg::PRE_WRAP);
			endcase
		end
	end

	// ----------------------------------------
	// Period end, strobes and compare values
	// ----------------------------------------
	assign match = (timer_reg == period_reg);
	assign period_end = tick && match;
	assign post_done = (post_reg ==
		tctl_reg[cpu_pkg::POST_HI:cpu_pkg::POST_LO]);
	// On-time that the coming period will use
	assign next_on_time = join_on_time(duty_low_reg,
		ctl_reg[cpu_pkg::CTL_DLSB_HI:cpu_pkg::CTL_DLSB_LO]);
	// Count the timer is about to show; comparing the current count
	// would hold the pin high one clock longer than the on-time
	assign ext_count = ext_of(timer_next, pre_next);
	assign on_time = join_on_time(duty_shadow_reg, hidden_lsb_reg);
	assign status_wr = wr_to(bus, cpu_pkg::ADDR_STATUS);

	// Quarter-cycle count advances every clock while the timer runs;
	// the divide-by-one prescale still uses it for the low bits
	always_comb begin
		pre_next = pre_reg;
		if (timer_run)
			pre_next = pre_reg + cpu_pkg::ONE2;
	end

	// Next timer value: clear on the increment after match
	always_comb begin
		timer_next = timer_reg;
		if (tick) begin
			if (match)
				timer_next = cpu_pkg::RST_ZERO;
			else
				timer_next = timer_reg + cpu_pkg::ONE8;
		end
	end

	// Quarter-cycle counter below the timer
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			pre_reg <= cpu_pkg::PRE_ZERO;
		else
			pre_reg <= pre_next;
	end

	// Timer register with software write
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			timer_reg <= cpu_pkg::RST_ZERO;
		else if (bus.wr && hit(bus.addr, cpu_pkg::ADDR_PERIOD_TIMER))
			timer_reg <= bus.wdata;
		else
			timer_reg <= timer_next;
	end

	// ----------------------------------------
	// Postscaler and period flag
	// ----------------------------------------
	// Postscaler paces only the period flag
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			post_reg <= cpu_pkg::POST_ONE;
		end else if (period_end) begin
			if (post_done)
				post_reg <= cpu_pkg::POST_ONE;
			else
				post_reg <= post_reg + cpu_pkg::ONE4;
		end
	end

	// Hardware set wins over a software write in the same clock,
	// so no period end is lost
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			flag_reg <= 1'b0;
		else if (period_end && post_done)
			flag_reg <= 1'b1;
		else if (status_wr)
			flag_reg <= bus.wdata[cpu_pkg::STATUS_FLAG_BIT];
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	// Control: mode field and the two duty low bits
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			ctl_reg <= cpu_pkg::RST_ZERO;
		else if (wr_to(bus, cpu_pkg::ADDR_UNIT_CONTROL))
			ctl_reg <= bus.wdata;
	end

	// Duty low byte, writable at any time
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			duty_low_reg <= cpu_pkg::RST_ZERO;
		else if (wr_to(bus, cpu_pkg::ADDR_DUTY_LOW))
			duty_low_reg <= bus.wdata;
	end

	// Period register
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			period_reg <= cpu_pkg::RST_PERIOD;
		else if (wr_to(bus, cpu_pkg::ADDR_PERIOD_REG))
			period_reg <= bus.wdata;
	end

	// Timer control: run bit, prescale select, postscale count
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			tctl_reg <= cpu_pkg::RST_ZERO;
		else if (wr_to(bus, cpu_pkg::ADDR_TIMER_CTRL))
			tctl_reg <= bus.wdata;
	end

	// Pin direction; only one bit steers the PWM pin
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			dir_reg <= cpu_pkg::RST_DIR;
		else if (wr_to(bus, cpu_pkg::ADDR_PIN_DIR))
			dir_reg <= bus.wdata;
	end

	// ----------------------------------------
	// Double buffer of the on-time
	// ----------------------------------------
	// Shadow loads at period end in PWM; writable otherwise
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			duty_shadow_reg <= cpu_pkg::RST_ZERO;
		else if (pwm_on && period_end)
			duty_shadow_reg <= duty_low_reg;
		else if (!pwm_on && wr_to(bus, cpu_pkg::ADDR_DUTY_SHADOW))
			duty_shadow_reg <= bus.wdata;
	end

	// Hidden two-bit latch, never visible to software
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			hidden_lsb_reg <= cpu_pkg::PRE_ZERO;
		else if (pwm_on && period_end)
			hidden_lsb_reg <=
				ctl_reg[cpu_pkg::CTL_DLSB_HI:cpu_pkg::CTL_DLSB_LO];
	end

	// ----------------------------------------
	// Output latch
	// ----------------------------------------
	// Set at period start, cleared on on-time match
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			latch_reg <= 1'b0;
		end else if (!pwm_on) begin
			latch_reg <= 1'b0;
		end else if (period_end) begin
			// Next period on-time is the value being loaded
			latch_reg <= (next_on_time != cpu_pkg::ON_TIME_ZERO);
		end else if (timer_run && ext_count == on_time) begin
			// An on-time past the period never matches: pin stays high
			latch_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// Pin level follows the output latch one clock later
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			PIN_OUT <= 1'b0;
		else
			PIN_OUT <= latch_reg;
	end

	// Pin driven only while the direction bit is clear
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			PIN_OE <= 1'b0;
		else
			PIN_OE <= ~dir_reg[cpu_pkg::PIN_DIR_BIT];
	end

	// Registered copy of the period flag
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			PERIOD_FLAG <= 1'b0;
		else
			PERIOD_FLAG <= flag_reg;
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Read mux, unmapped reads return zero
	always_comb begin
		rdata_next = cpu_pkg::RST_ZERO;
		case (bus.addr)
		cpu_pkg::ADDR_UNIT_CONTROL: rdata_next = ctl_reg;
		cpu_pkg::ADDR_DUTY_LOW: rdata_next = duty_low_reg;
		cpu_pkg::ADDR_DUTY_SHADOW: rdata_next = duty_shadow_reg;
		cpu_pkg::ADDR_PERIOD_REG: rdata_next = period_reg;
		cpu_pkg::ADDR_PERIOD_TIMER: rdata_next = timer_reg;
		cpu_pkg::ADDR_TIMER_CTRL: rdata_next = tctl_reg;
		cpu_pkg::ADDR_PIN_DIR: rdata_next = dir_reg;
		cpu_pkg::ADDR_STATUS: rdata_next = {7'h00, flag_reg};
		default: rdata_next = cpu_pkg::RST_ZERO;
		endcase
	end

	// Read data stands one cycle after the strobe only
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			RDATA <= cpu_pkg::RST_ZERO;
		else if (bus.rd)
			RDATA <= rdata_next;
		else
			RDATA <= cpu_pkg::RST_ZERO;
	end
endmodule : cpu_pwm_unit

// file: tb/cpu_pwm_unit_properties.sv
`timescale 1ns/1ns
module cpu_pwm_chk (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic PIN_OUT,
	input wire logic PIN_OE,
	input wire logic PERIOD_FLAG
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	logic [7:0] ctl_reg;
	logic [7:0] duty_reg;
	// Copies of control and duty low
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctl_reg <= 8'h00;
			duty_reg <= 8'h00;
		end else if (WR && ADDR == cpu_pkg::ADDR_UNIT_CONTROL) begin
			ctl_reg <= WDATA;
		end else if (WR && ADDR == cpu_pkg::ADDR_DUTY_LOW) begin
			duty_reg <= WDATA;
		end
	end
	// ----
	// Properties
	// ----
	rdata_idle_a: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data not idle");
	unmapped_rd_a: assert property (RD && ADDR == 8'h01 |=> RDATA == 8'h00)
		else $error("unmapped read not zero");
	reg_echo_a: assert property (WR && ADDR == cpu_pkg::ADDR_DUTY_LOW
		##2 RD && ADDR == cpu_pkg::ADDR_DUTY_LOW |=>
		RDATA == $past(WDATA, 3))
		else $error("read back differs");
	ctl_zero_a: assert property (WR && WDATA == 8'h00 &&
		ADDR == cpu_pkg::ADDR_UNIT_CONTROL |-> ##3 !PIN_OUT)
		else $error("pin high after control cleared");
	mode_gate_a: assert property (ctl_reg[3:2] != 2'h3 |-> ##2 !PIN_OUT)
		else $error("pin high outside pwm mode");
	oe_follow_a: assert property (WR && ADDR == cpu_pkg::ADDR_PIN_DIR
		|-> ##2 PIN_OE == !$past(WDATA[2], 2))
		else $error("enable not following direction");
	oe_hold_a: assert property (!(WR && ADDR == cpu_pkg::ADDR_PIN_DIR)
		|-> ##2 $stable(PIN_OE))
		else $error("enable moved without write");
	duty_zero_a: assert property ($rose(PIN_OUT) |->
		$past({duty_reg, ctl_reg[5:4]}, 2) != 10'h000)
		else $error("pin set with zero on-time");
	cover property ($rose(PIN_OUT));
	cover property ($fell(PIN_OUT));
	cover property (WR && ADDR == cpu_pkg::ADDR_DUTY_SHADOW);
endmodule : cpu_pwm_chk

// file: tb/cpu_pwm_load.sv
`timescale 1ns/1ns
module cpu_pwm_load (
	input wire logic clk,
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic [15:0] hi_cnt
);
	logic pin_level;
	// Pull-down holds the line low when undriven
	assign pin_level = pin_oe ? pin_out : 1'b0;
	initial hi_cnt = 16'h0000;
	// Counts clocks with the line high
	always @(posedge clk) begin
		if (pin_level === 1'b1) begin
			hi_cnt <= hi_cnt + 16'h0001;
		end
	end
endmodule : cpu_pwm_load

// file: tb/cpu_pwm_unit_tb_top.sv
`timescale 1ns/1ns
module cpu_pwm_unit_tb_top;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic pin_out;
	logic pin_oe;
	logic period_flag;
	logic [15:0] hi_cnt;
	logic [15:0] hi_base;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	// Clock and hang guard
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			final_report();
		end
	end
	cpu_pwm_unit uut (.CORE_CLK(core_clk), .RST_N(rst_n), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PIN_OUT(pin_out),
		.PIN_OE(pin_oe), .PERIOD_FLAG(period_flag));
	cpu_pwm_load u_load (.clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.hi_cnt(hi_cnt));
	// ----
	// Tasks
	// ----
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
		@(posedge core_clk);
	endtask : wr_reg
	task rd_reg(input logic [7:0] a, input logic [7:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		@(negedge core_clk);
		chk({8'h00, rdata}, {8'h00, exp});
		@(posedge core_clk);
	endtask : rd_reg
	// Settle, then count high clocks over four periods
	task pwm_hi(input logic [15:0] exp);
		repeat (24) @(posedge core_clk);
		hi_base = hi_cnt;
		repeat (32) @(posedge core_clk);
		chk(hi_cnt - hi_base, exp);
		$display("pwm test done");
	endtask : pwm_hi
	task final_report;
		$display("checks %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report
	// Main sequence
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rd_reg(cpu_pkg::ADDR_PERIOD_REG, cpu_pkg::RST_PERIOD);
		rd_reg(cpu_pkg::ADDR_PIN_DIR, cpu_pkg::RST_DIR);
		rd_reg(cpu_pkg::ADDR_UNIT_CONTROL, cpu_pkg::RST_ZERO);
		rd_reg(8'h01, 8'h00);
		$display("reset test done");
		wr_reg(cpu_pkg::ADDR_PERIOD_REG, 8'h01);
		wr_reg(cpu_pkg::ADDR_TIMER_CTRL, 8'h05);
		wr_reg(cpu_pkg::ADDR_PIN_DIR, 8'hfb);
		wr_reg(cpu_pkg::ADDR_DUTY_LOW, 8'h01);
		rd_reg(cpu_pkg::ADDR_DUTY_LOW, 8'h01);
		wr_reg(cpu_pkg::ADDR_UNIT_CONTROL, 8'h0c);
		pwm_hi(16'h0010);
		chk({15'h0000, period_flag}, 16'h0001);
		rd_reg(cpu_pkg::ADDR_STATUS, 8'h01);
		rd_reg(cpu_pkg::ADDR_DUTY_SHADOW, 8'h01);
		wr_reg(cpu_pkg::ADDR_DUTY_SHADOW, 8'h55);
		rd_reg(cpu_pkg::ADDR_DUTY_SHADOW, 8'h01);
		wr_reg(cpu_pkg::ADDR_UNIT_CONTROL, 8'h2c);
		pwm_hi(16'h0018);
		wr_reg(cpu_pkg::ADDR_DUTY_LOW, 8'h03);
		pwm_hi(16'h0020);
		wr_reg(cpu_pkg::ADDR_DUTY_LOW, 8'h00);
		wr_reg(cpu_pkg::ADDR_UNIT_CONTROL, 8'h0c);
		pwm_hi(16'h0000);
		wr_reg(cpu_pkg::ADDR_DUTY_LOW, 8'h01);
		wr_reg(cpu_pkg::ADDR_PIN_DIR, 8'hff);
		pwm_hi(16'h0000);
		wr_reg(cpu_pkg::ADDR_PIN_DIR, 8'hfb);
		wr_reg(cpu_pkg::ADDR_UNIT_CONTROL, 8'h00);
		pwm_hi(16'h0000);
		final_report();
	end
endmodule : cpu_pwm_unit_tb_top
bind cpu_pwm_unit cpu_pwm_chk u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PERIOD_FLAG(PERIOD_FLAG));
